// File: fape_host.sv
// Summary of operation
// - after a program the host polls the polarity and toggle bits for the end.
// - chip erase starts with two consecutive writes of 30H.
// - after the erase starts the host polls the status bits for the end.
// - the host polls the toggle bit until it stops or the time limit runs out, then judges pass or fail.
// - the host raises the programming supply before the first erase command.
// - chip and output enable stay high while the supply switches.
// - the supply never switches while chip enable is low.
// - two writes of FFH abort a setup or clear a failure.
`default_nettype none
module fape_host
  import fape_pkg::*;
#(
  parameter longint PROG_TOUT  = PROG_TOUT_CYC,
  parameter longint ERASE_TOUT = ERASE_TOUT_CYC
) (
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic [17:0]      flash_addr_o,
  input  wire logic [7:0]  flash_dq_i,
  output logic [7:0]       flash_dq_o,
  output logic             flash_dq_oe_o,
  output logic             flash_ce_n_o,
  output logic             flash_oe_n_o,
  output logic             flash_we_n_o,
  output logic             program_supply_high_o
);
  // the timeout counter is 40 bits wide, so larger limits cannot be served
  if (PROG_TOUT < 1 || ERASE_TOUT < 1 ||
      PROG_TOUT >= (longint'(1) << 40) ||
      ERASE_TOUT >= (longint'(1) << 40)) begin : g_bad_tout
    $error("timeouts must be positive and below 2**40 cycles");
  end

  localparam int VW = $clog2(VPP_SETUP_CYC + 1);

  fape_state_t st_reg, st_next;
  logic [17:0] addr_reg, addr_next;
  logic [7:0]  wdat_reg, wdat_next;
  logic [7:0]  rdat_reg, rdat_next;
  logic [7:0]  prev_reg, prev_next;
  logic        erase_reg, erase_next;
  logic        done_reg, done_next, fail_reg, fail_next, tout_reg, tout_next;
  logic        vpp_reg, vpp_next;
  logic        then_rst_reg, then_rst_next;
  logic [VW-1:0] vcnt_reg, vcnt_next;
  logic [39:0] tcnt_reg, tcnt_next;

  logic       bc_start, bc_write, bc_done;
  logic [7:0] bc_wdata, bc_rdata;

  fape_bus_cycle u_cyc (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .start_i   (bc_start),
    .write_i   (bc_write),
    .wdata_i   (bc_wdata),
    .dq_i      (flash_dq_i),
    .ce_n_o    (flash_ce_n_o),
    .oe_n_o    (flash_oe_n_o),
    .we_n_o    (flash_we_n_o),
    .dq_o      (flash_dq_o),
    .dq_oe_o   (flash_dq_oe_o),
    .rdata_o   (bc_rdata),
    .done_o    (bc_done)
  );

  logic apb_wr, busy;
  assign apb_wr    = psel_i && penable_i && pwrite_i;
  assign busy      = st_reg != ST_IDLE;
  assign pready_o  = 1'b1;
  assign pslverr_o = 1'b0;

  always_comb begin
    prdata_o = '0;
    unique case (paddr_i)
      REG_ADDR:   prdata_o = {14'h0000, addr_reg};
      REG_WDATA:  prdata_o = {24'h00_0000, wdat_reg};
      REG_STATUS: prdata_o = {27'h000_0000, vpp_reg, tout_reg, fail_reg, done_reg, busy};
      REG_RDATA:  prdata_o = {24'h00_0000, rdat_reg};
      default:    prdata_o = '0;
    endcase
  end

  // supply ramps are not counted, only time spent on the flash bus
  logic tlimit;
  assign tlimit = erase_reg ? (tcnt_reg >= 40'(ERASE_TOUT)) : (tcnt_reg >= 40'(PROG_TOUT));

  always_comb begin
    st_next       = st_reg;
    addr_next     = addr_reg;
    wdat_next     = wdat_reg;
    rdat_next     = rdat_reg;
    prev_next     = prev_reg;
    erase_next    = erase_reg;
    done_next     = done_reg;
    fail_next     = fail_reg;
    tout_next     = tout_reg;
    vpp_next      = vpp_reg;
    then_rst_next = then_rst_reg;
    vcnt_next     = vcnt_reg;
    tcnt_next     = tcnt_reg;
    bc_start      = 1'b0;
    bc_write      = 1'b1;
    bc_wdata      = CMD_RESET;
    if (apb_wr && !busy && paddr_i == REG_ADDR) addr_next = pwdata_i[17:0];
    if (apb_wr && !busy && paddr_i == REG_WDATA) wdat_next = pwdata_i[7:0];
    if (st_reg != ST_IDLE && st_reg != ST_VUP && st_reg != ST_VDN) tcnt_next = tcnt_reg + 40'd1;
    unique case (st_reg)
      ST_IDLE: if (apb_wr && paddr_i == REG_CTRL) begin
        done_next = 1'b0;
        fail_next = 1'b0;
        tout_next = 1'b0;
        tcnt_next = '0;
        if (pwdata_i[CTRL_ERASE] || pwdata_i[CTRL_PROG]) begin
          erase_next = pwdata_i[CTRL_ERASE];
          vpp_next   = 1'b1;
          vcnt_next  = '0;
          st_next    = ST_VUP;
        end else if (pwdata_i[CTRL_ABORT]) begin
          then_rst_next = 1'b0;
          st_next = ST_RST1;
        end else if (pwdata_i[CTRL_READ]) begin
          st_next = ST_RD;
        end
      end
      // bus cycler idle keeps ce high during the supply switch
      ST_VUP: begin
        vcnt_next = vcnt_reg + VW'(1);
        if (vcnt_reg == VW'(VPP_SETUP_CYC)) st_next = ST_WR1;
      end
      ST_WR1: begin
        bc_start = 1'b1;
        bc_wdata = erase_reg ? CMD_ERASE : CMD_PROG;
        if (bc_done) st_next = ST_WR2;
      end
      ST_WR2: begin
        bc_start = 1'b1;
        bc_wdata = erase_reg ? CMD_ERASE : wdat_reg;
        if (bc_done) st_next = ST_POLL1;
      end
      ST_POLL1: begin
        bc_start = 1'b1;
        bc_write = 1'b0;
        if (bc_done) begin
          prev_next = bc_rdata;
          st_next   = ST_POLL2;
        end
      end
      ST_POLL2: begin
        bc_start = 1'b1;
        bc_write = 1'b0;
        // the limit is judged only after a whole read, never mid cycle
        if (bc_done) begin
          prev_next = bc_rdata;
          if (bc_rdata[TOGGLE_BIT] == prev_reg[TOGGLE_BIT]) begin
            st_next = ST_CHECK;
          end else if (tlimit) begin
            tout_next = 1'b1;
            fail_next = 1'b1;
            st_next   = ST_VDN;
          end
        end
      end
      ST_CHECK: begin
        // erase ends with 1, program with the true written bit
        if (prev_reg[POLL_BIT] == (erase_reg ? 1'b1 : wdat_reg[POLL_BIT]))
          done_next = 1'b1;
        else fail_next = 1'b1;
        st_next = ST_VDN;
      end
      ST_VDN: begin
        vpp_next = 1'b0;
        then_rst_next = fail_reg;
        st_next = fail_reg ? ST_RST1 : ST_FIN;
      end
      ST_RST1: begin
        bc_start = 1'b1;
        if (bc_done) st_next = ST_RST2;
      end
      ST_RST2: begin
        bc_start = 1'b1;
        if (bc_done) st_next = ST_FIN;
      end
      ST_RD: begin
        bc_start = 1'b1;
        bc_write = 1'b0;
        if (bc_done) begin
          rdat_next = bc_rdata;
          done_next = 1'b1;
          st_next   = ST_IDLE;
        end
      end
      ST_FIN: begin
        if (!then_rst_reg && !fail_reg && !tout_reg) done_next = 1'b1;
        st_next = ST_IDLE;
      end
      default: st_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_reg       <= ST_IDLE;
      addr_reg     <= '0;
      wdat_reg     <= '0;
      rdat_reg     <= '0;
      prev_reg     <= '0;
      erase_reg    <= 1'b0;
      done_reg     <= 1'b0;
      fail_reg     <= 1'b0;
      tout_reg     <= 1'b0;
      vpp_reg      <= 1'b0;
      then_rst_reg <= 1'b0;
      vcnt_reg     <= '0;
      tcnt_reg     <= '0;
    end else begin
      st_reg       <= st_next;
      addr_reg     <= addr_next;
      wdat_reg     <= wdat_next;
      rdat_reg     <= rdat_next;
      prev_reg     <= prev_next;
      erase_reg    <= erase_next;
      done_reg     <= done_next;
      fail_reg     <= fail_next;
      tout_reg     <= tout_next;
      vpp_reg      <= vpp_next;
      then_rst_reg <= then_rst_next;
      vcnt_reg     <= vcnt_next;
      tcnt_reg     <= tcnt_next;
    end
  end

  assign flash_addr_o          = addr_reg;
  assign program_supply_high_o = vpp_reg;

  chk_supply_ce_high: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    $changed(vpp_reg) |-> flash_ce_n_o && flash_oe_n_o)
    else $error("supply switched with chip enabled");
  chk_vpp_before_cmd: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !flash_we_n_o && erase_reg && st_reg == ST_WR1 |-> vpp_reg)
    else $error("erase command without high supply");
  chk_vpp_setup_time: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    $rose(vpp_reg) |-> flash_ce_n_o [*8])
    else $error("chip enabled too soon after supply rise");
  chk_erase_cmd_data: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !flash_we_n_o && erase_reg && (st_reg == ST_WR1 || st_reg == ST_WR2)
      |-> flash_dq_o == CMD_ERASE && flash_dq_oe_o)
    else $error("erase command byte wrong");
  chk_reset_cmd_data: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !flash_we_n_o && (st_reg == ST_RST1 || st_reg == ST_RST2) |-> flash_dq_o == CMD_RESET)
    else $error("reset command byte wrong");
  chk_poll_no_drive: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !flash_oe_n_o |-> !flash_dq_oe_o && flash_we_n_o)
    else $error("host drives data while reading");
  chk_stop_to_check: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    st_reg == ST_CHECK |=> st_reg == ST_VDN ##1 !vpp_reg)
    else $error("check did not finish");
  chk_erase_pass: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    st_reg == ST_CHECK && erase_reg && prev_reg[POLL_BIT] |=> done_reg)
    else $error("erase pass not reported");
  chk_prog_fail: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    st_reg == ST_CHECK && !erase_reg && prev_reg[POLL_BIT] != wdat_reg[POLL_BIT] |=> fail_reg)
    else $error("program miss not reported");
  chk_poll_read_only: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (st_reg == ST_POLL1 || st_reg == ST_POLL2) |-> flash_we_n_o && !flash_dq_oe_o)
    else $error("host writes while polling status");
  chk_toggle_keeps_poll: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    st_reg == ST_POLL2 && bc_done && bc_rdata[TOGGLE_BIT] != prev_reg[TOGGLE_BIT] |=> st_reg != ST_CHECK)
    else $error("status judged while toggle bit still moves");
  chk_timeout_is_fail: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    $rose(tout_reg) |-> fail_reg)
    else $error("timeout not reported as failure");
  chk_fail_sends_reset: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    st_reg == ST_VDN && fail_reg |=> st_reg == ST_RST1)
    else $error("failure not followed by reset writes");

  cov_erase: cover property (@(posedge ref_clk_i) st_reg == ST_CHECK && erase_reg);
  cov_prog: cover property (@(posedge ref_clk_i) st_reg == ST_CHECK && !erase_reg);
  cov_abort: cover property (@(posedge ref_clk_i) st_reg == ST_RST2 && bc_done);
  cov_timeout: cover property (@(posedge ref_clk_i) $rose(tout_reg));
  cov_read: cover property (@(posedge ref_clk_i) st_reg == ST_RD && bc_done);
endmodule : fape_host
`default_nettype wire

// File: fape_pkg.sv
`default_nettype none
package fape_pkg;
  // apb register map of the controller
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  // ctrl write bits (self clearing starts)
  localparam int CTRL_PROG  = 0;
  localparam int CTRL_ERASE = 1;
  localparam int CTRL_ABORT = 2;
  localparam int CTRL_READ  = 3;
  // status bits
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_TOUT = 3;
  localparam int ST_VPP  = 4;
  // device commands
  localparam logic [7:0] CMD_ERASE = 8'h30;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] CMD_PROG  = 8'h40;
  // status line positions on the data bus
  localparam int POLL_BIT   = 7;
  localparam int TOGGLE_BIT = 6;
  // timing, 125 MHz
  localparam int CLK_MHZ        = 125;
  localparam int VPP_SETUP_NS   = 100;
  localparam int BUS_PHASE_NS   = 120;
  localparam int VPP_SETUP_CYC  = (VPP_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int BUS_PHASE_CYC  = (BUS_PHASE_NS * CLK_MHZ + 999) / 1000;
  localparam int PROG_MAX_US    = 300;
  localparam int ERASE_TYP_S    = 5;
  localparam longint PROG_TOUT_CYC  = longint'(PROG_MAX_US) * CLK_MHZ;
  localparam longint ERASE_TOUT_CYC = longint'(ERASE_TYP_S) * 1000000 * CLK_MHZ * 2;
  typedef enum logic [11:0] {
    ST_IDLE  = 12'h001, ST_VUP   = 12'h002, ST_WR1   = 12'h004, ST_WR2  = 12'h008,
    ST_POLL1 = 12'h010, ST_POLL2 = 12'h020, ST_CHECK = 12'h040, ST_VDN  = 12'h080,
    ST_RST1  = 12'h100, ST_RST2  = 12'h200, ST_RD    = 12'h400, ST_FIN  = 12'h800
  } fape_state_t;
endpackage : fape_pkg
`default_nettype wire

// File: fape_bus_cycle.sv
`default_nettype none
// one write or read cycle on the flash pins, each phase BUS_PHASE_CYC long
module fape_bus_cycle
  import fape_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       start_i,
  input  wire logic       write_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic [7:0] dq_i,
  output logic            ce_n_o,
  output logic            oe_n_o,
  output logic            we_n_o,
  output logic [7:0]      dq_o,
  output logic            dq_oe_o,
  output logic [7:0]      rdata_o,
  output logic            done_o
);
  localparam int CW = $clog2(BUS_PHASE_CYC * 3 + 1);
  localparam logic [CW-1:0] PH = CW'(BUS_PHASE_CYC);
  logic [CW-1:0] cnt_reg, cnt_next;
  logic          act_reg, act_next, wr_reg, wr_next;
  logic [7:0]    wd_reg, wd_next, rd_reg, rd_next;

  always_comb begin
    cnt_next = cnt_reg;
    act_next = act_reg;
    wr_next  = wr_reg;
    wd_next  = wd_reg;
    rd_next  = rd_reg;
    done_o   = 1'b0;
    if (!act_reg && start_i) begin
      act_next = 1'b1;
      wr_next  = write_i;
      wd_next  = wdata_i;
      cnt_next = '0;
    end else if (act_reg) begin
      cnt_next = cnt_reg + CW'(1);
      if (!wr_reg && cnt_reg == PH * CW'(2) - CW'(1)) rd_next = dq_i;
      if (cnt_reg == PH * CW'(3) - CW'(1)) begin
        act_next = 1'b0;
        done_o   = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_reg <= '0;
      act_reg <= 1'b0;
      wr_reg  <= 1'b0;
      wd_reg  <= '0;
      rd_reg  <= '0;
    end else begin
      cnt_reg <= cnt_next;
      act_reg <= act_next;
      wr_reg  <= wr_next;
      wd_reg  <= wd_next;
      rd_reg  <= rd_next;
    end
  end

  // write strobe only in the middle phase, oe low through middle and last phase of a read; first phase gives setup, last gives write hold
  logic mid;
  assign mid     = act_reg && cnt_reg >= PH && cnt_reg < PH * CW'(2);
  assign ce_n_o  = !act_reg;
  assign we_n_o  = !(mid && wr_reg);
  assign oe_n_o  = !(act_reg && !wr_reg && cnt_reg >= PH);
  assign dq_oe_o = act_reg && wr_reg;
  assign dq_o    = wd_reg;
  assign rdata_o = rd_reg;
endmodule : fape_bus_cycle
`default_nettype wire

// File: fape_flash_model.sv
`default_nettype none
module fape_flash_model
  import fape_pkg::*;
(
  input  wire logic [17:0] addr_i,
  input  wire logic [7:0]  dq_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        vpp_i,
  input  wire logic        fail_i,
  input  var  int          busy_ns_i,
  output var  logic [7:0]  dq_o,
  output logic             dq_en_o,
  output var  int          viol_o,
  output var  int          resets_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [logic [17:0]];
  logic [7:0]  last;
  logic [17:0] la;
  logic        tog;
  logic        poll;
  logic        ff1;
  logic        er;
  int          mode;  // 0 read, 1 program setup, 2 erase setup, 3 busy, 4 failed
  initial begin
    mode = 0;
    {tog, poll, ff1, er} = 4'h0;
    last = 8'h00;
    la = 18'h0_0000;
    dq_o = 8'h00;
    viol_o = 0;
    resets_o = 0;
  end
  assign dq_en_o = !ce_n_i && !oe_n_i;
  task automatic run();
    mode = 3;
    poll = er ? 1'b0 : ~last[7];
    #(busy_ns_i);
    if (fail_i) begin
      mode = 4;
    end else begin
      if (er) mem.delete();
      else mem[la] = (mem.exists(la) ? mem[la] : 8'hFF) & last;
      mode = 0;
    end
  endtask
  // writes during busy are ignored, so a stuck op stays stuck
  always @(posedge we_n_i) begin
    if (ce_n_i === 1'b0 && mode != 3) begin
      if (ff1 && dq_i == CMD_RESET) begin
        mode = 0;
        resets_o++;
      end else if (mode == 1) begin
        la = addr_i;
        last = dq_i;
        er = 1'b0;
        fork run(); join_none
      end else if (mode == 2) begin
        if (dq_i == CMD_ERASE) begin
          er = 1'b1;
          fork run(); join_none
        end else mode = 0;
      end else if (mode == 0 && dq_i == CMD_PROG) begin
        mode = 1;
      end else if (mode == 0 && dq_i == CMD_ERASE) begin
        mode = 2;
        if (vpp_i !== 1'b1) viol_o++;
      end
      ff1 = (dq_i == CMD_RESET) && !ff1;
    end
  end
  always @(negedge oe_n_i) begin
    if (mode == 3) tog = ~tog;
    // floating low lines shown as a changing pattern
    if (mode >= 3) dq_o = {poll, tog, ~dq_o[5:0]};
    else dq_o = mem.exists(addr_i) ? mem[addr_i] : 8'hFF;
  end
  always @(vpp_i) if (ce_n_i === 1'b0 || oe_n_i === 1'b0) viol_o++;
endmodule // fape_flash_model
`default_nettype wire

// File: flash_auto_program_chip_erase_tb_top.sv
`default_nettype none
module flash_auto_program_chip_erase_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fape_pkg::*;
  logic        ref_clk_i, sys_rst_i, psel, penable, pwrite, pready, pslverr;
  logic        hoe, men, ce_n, oe_n, we_n, vpp, fail;
  logic [7:0]  paddr, hdq, mdq, bus, d;
  logic [17:0] faddr, a;
  logic [31:0] pwdata, prdata, r;
  int          busy_ns, viol, resets, err_total, n_compared, seed, k, k2;
  logic [7:0]  exp_mem [logic [17:0]];
  // nobody driving: inverse value, so a stale read cannot pass
  assign bus = hoe ? hdq : (men ? mdq : ~mdq);
  fape_host #(.PROG_TOUT(8000), .ERASE_TOUT(20000)) fape_host_inst (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .flash_addr_o(faddr), .flash_dq_i(bus),
    .flash_dq_o(hdq), .flash_dq_oe_o(hoe), .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n),
    .flash_we_n_o(we_n), .program_supply_high_o(vpp));
  fape_flash_model fape_flash_model_inst (
    .addr_i(faddr), .dq_i(bus), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .vpp_i(vpp),
    .fail_i(fail), .busy_ns_i(busy_ns), .dq_o(mdq), .dq_en_o(men), .viol_o(viol),
    .resets_o(resets));
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do @(posedge ref_clk_i); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic op(input int b);
    apb(1'b1, REG_CTRL, 32'h0000_0001 << b);
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    if (b <= CTRL_ERASE) chk(r[4:0], 5'h11);
    k = 0;
    while (r[ST_BUSY] !== 1'b0 && k < 10000) begin
      apb(1'b0, REG_STATUS, 32'h0000_0000);
      k++;
    end
    if (k >= 10000) err_total++;
  endtask
  task automatic prog(input logic [17:0] pa, input logic [7:0] pd);
    apb(1'b1, REG_ADDR, {14'h0, pa});
    apb(1'b1, REG_WDATA, {24'h00_0000, pd});
    op(CTRL_PROG);
  endtask
  task automatic rd_chk(input logic [17:0] pa);
    apb(1'b1, REG_ADDR, {14'h0, pa});
    op(CTRL_READ);
    apb(1'b0, REG_RDATA, 32'h0000_0000);
    chk(r[7:0], exp_mem.exists(pa) ? exp_mem[pa] : 8'hFF);
  endtask
  initial begin
    {psel, penable, pwrite, fail} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    busy_ns = 15000;
    seed = 32'hc54c3cab;
    sys_rst_i = 1'b1;
    repeat (20) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge ref_clk_i);
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    chk(r, 32'h0000_0000);
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk(r, 32'h0000_0000);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      a = 18'($random(seed));
      d = 8'($random(seed));
      busy_ns <= 15000 * (i + 1);
      prog(a, d);
      chk(r[3:0], 4'h2);
      exp_mem[a] = (exp_mem.exists(a) ? exp_mem[a] : 8'hFF) & d;
      rd_chk(a);
    end
    $display("test program done");
    busy_ns <= 40000;
    op(CTRL_ERASE);
    chk(r[3:0], 4'h2);
    exp_mem.delete();
    rd_chk(a);
    $display("test erase done");
    k2 = resets;
    fail <= 1'b1;
    busy_ns <= 15000;
    prog(a, 8'h5A);
    chk(r[ST_FAIL], 1'b1);
    chk(resets, k2 + 1);
    fail <= 1'b0;
    rd_chk(a);
    op(CTRL_ABORT);
    chk(r[3:0], 4'h2);
    chk(resets, k2 + 2);
    $display("test fail done");
    busy_ns <= 1000000;
    prog(a, 8'h11);
    chk(r[3:2], 2'b11);
    chk(viol, 0);
    $display("test timeout done");
    test_done();
  end
  initial begin
    #400000;
    err_total++;
    test_done();
  end
endmodule // flash_auto_program_chip_erase_tb_top
`default_nettype wire
